// *** src/tfc_cache.sv ***
// texture fetch cache: direct-mapped texel cache plus palette cache
// assumes a video memory read port returning one halfword per valid cycle, in order
`timescale 1ns/1ps
// Operation
// (R1) mask bit set blocks pixel overwrite
// (R2) 24-bit pixels packed three bytes, red first
// (R3) only raw transfers emit 24-bit pixels
// (R4) direct texel splits red, green, blue
// (R5) zero texel transparent, others opaque
// (R6) flag blends only under semi commands
// (R7) 8-bit word holds two indices
// (R8) 4-bit word holds four indices
// (R9) texture coordinates limited to 8 bits
// (R10) page base on 64 by 256 grid
// (R11) palette read as one row
// (R12) palette x multiple of 16, row bounded
// (R13) palette cache kept until change or clear; a clear while a palette load runs is lost
// (R14) 2 Kbyte texture cache
// (R15) block size depends on colour mode
// (R16) blocks tile the page
// (R17) 256 entries of 8 bytes per block
// (R18) entry holds 16, 8 or 4 texels
// (R19) direct-mapped, same entry number evicts
// (R20) texture window repeats the texture
// (R21) miss fetches whole entry first
module tfc_cache
#(
  parameter bit VRAM_2MB = 1'b0
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire tfc_pkg::tfc_req_t req,
  output logic req_ready,
  output logic out_valid,
  output tfc_pkg::tfc_texel_t out_texel,
  input wire logic pal_clear,
  output logic vr_valid,
  output tfc_pkg::tfc_vaddr_t vr_addr,
  input wire logic vd_valid,
  input wire logic [15:0] vd_data,
  input wire logic raw_valid,
  input wire logic [47:0] raw_rgb,
  input wire logic [15:0] fb_old,
  input wire logic fb_check_mask,
  output logic raw_out_valid,
  output logic [47:0] raw_out,
  output logic fb_write_ok
);
  import tfc_pkg::*;
  typedef enum logic [2:0] {
    TFC_IDLE = 3'b000,
    TFC_LOOK = 3'b001,
    TFC_FILL = 3'b010,
    TFC_PAL = 3'b011,
    TFC_DONE = 3'b100
  } tfc_state_t;
  localparam int LINES = TFC_CACHE_BYTES / (TFC_ENTRY_HW * 2); // R14
  localparam int PAL_MAX = TFC_PAL_LEN_8;
  // the whole control state
  typedef struct packed {
    tfc_state_t st;
    tfc_req_t q;
    logic [7:0] u;
    logic [7:0] v;
    logic [7:0] entry;
    logic [1:0] hw;
    logic [1:0] sub;
    logic [TFC_VX_W-1:0] bx;
    logic [TFC_VY_W-1:0] by;
    logic [1:0] fcnt;
    logic [1:0] rcnt;
    logic [8:0] pcnt;
    logic [8:0] prcv;
    logic pal_ok;
    tfc_mode_t pal_mode;
    logic [5:0] pal_x;
    logic [9:0] pal_y;
    logic out_valid;
    tfc_texel_t out_texel;
    logic vr_valid;
    tfc_vaddr_t vr_addr;
    logic raw_out_valid;
    logic [47:0] raw_out;
    logic fb_write_ok;
    logic req_ready; // high while idle from the first edge after reset, drives the port
  } tfc_st_t;
  tfc_st_t s_r, s_nxt;
  // storage arrays
  logic [15:0] data_mem [LINES][TFC_ENTRY_HW];
  logic [15:0] tag_mem [LINES];
  logic valid_mem [LINES];
  logic [15:0] pal_mem [PAL_MAX];
  logic [15:0] tag_now;
  logic hit;
  logic [15:0] word_now;
  logic [7:0] index;
  logic [15:0] color;
  tfc_texel_t dec_texel;
  logic write_ok;
  logic [47:0] packed_bytes;
  logic fill_we;
  logic pal_we;
  // window: (coord and not mask) or (offset and mask), 8-texel units
  function automatic logic [7:0] win_apply(input logic [7:0] c, input logic [4:0] m, input logic [4:0] o);
    logic [7:0] mm;
    mm = {m, 3'b000};
    win_apply = (c & ~mm) | ({o, 3'b000} & mm); // R20
  endfunction
  // block tag: page, mode, block column and row
  function automatic logic [15:0] make_tag(input tfc_req_t r, input logic [7:0] u, input logic [7:0] v);
    logic [2:0] bcol;
    logic [2:0] brow;
    case (r.mode)
      TFC_MODE_4BIT: begin bcol = {1'b0, u[7:6]}; brow = {1'b0, v[7:6]}; end // R15
      TFC_MODE_8BIT: begin bcol = u[7:5]; brow = {1'b0, v[7:6]}; end // R15
      default: begin bcol = u[7:5]; brow = v[7:5]; end // R15
    endcase
    make_tag = {1'b1, r.mode, r.page_x, r.page_y, 2'b00, bcol, brow}; // R16
  endfunction
  // entry number within the block, 256 of them
  function automatic logic [7:0] make_entry(input tfc_mode_t m, input logic [7:0] u, input logic [7:0] v);
    make_entry = (m == TFC_MODE_4BIT) ? {v[5:0], u[5:4]} // R18
               : (m == TFC_MODE_8BIT) ? {v[5:0], u[4:3]} : {v[4:0], u[4:2]}; // R18
  endfunction
  // halfword within the entry and texel within the halfword
  function automatic logic [3:0] make_hwsub(input tfc_mode_t m, input logic [7:0] u);
    make_hwsub = (m == TFC_MODE_4BIT) ? {u[3:2], u[1:0]}
               : (m == TFC_MODE_8BIT) ? {u[2:1], 1'b0, u[0]} : {u[1:0], 2'b00};
  endfunction
  assign tag_now = make_tag(s_r.q, s_r.u, s_r.v);
  assign hit = valid_mem[s_r.entry] && (tag_mem[s_r.entry] == tag_now);
  assign word_now = data_mem[s_r.entry][s_r.hw];
  assign color = (s_r.q.mode == TFC_MODE_16BIT) ? word_now : pal_mem[index];
  assign fill_we = (s_r.st == TFC_FILL) && vd_valid;
  assign pal_we = (s_r.st == TFC_PAL) && vd_valid;
  tfc_decode u_dec (
    .word(word_now),
    .mode(s_r.q.mode),
    .sub(s_r.sub),
    .index(index),
    .color(color),
    .semi_cmd(s_r.q.semi_cmd),
    .texel(dec_texel)
  );
  tfc_pixel_pack u_pack (
    .old_pixel(fb_old),
    .check_mask(fb_check_mask),
    .write_ok(write_ok),
    .two_rgb24(raw_rgb),
    .packed_bytes(packed_bytes)
  );
  // next-state logic
  always_comb begin
    logic [3:0] hs;
    logic [TFC_VX_W-1:0] base_x;
    s_nxt = s_r;
    hs = 4'h0;
    base_x = '0;
    s_nxt.out_valid = 1'b0;
    // raw transfers are the only 24-bit path
    s_nxt.raw_out_valid = raw_valid; // R3
    s_nxt.raw_out = packed_bytes; // R2
    s_nxt.fb_write_ok = write_ok; // R1
    // palette clear command
    if (pal_clear) begin
      s_nxt.pal_ok = 1'b0; // R13
    end
    case (s_r.st)
      TFC_IDLE: begin
        if (req_valid && s_r.req_ready) begin
          s_nxt.q = req;
          // 8-bit coordinates, window folded in
          s_nxt.u = win_apply(req.u, req.win_mask_x, req.win_off_x); // R9
          s_nxt.v = win_apply(req.v, req.win_mask_y, req.win_off_y); // R9
          s_nxt.st = TFC_LOOK;
        end
      end
      TFC_LOOK: begin
        hs = make_hwsub(s_r.q.mode, s_r.u);
        s_nxt.entry = make_entry(s_r.q.mode, s_r.u, s_r.v); // R17 R19
        s_nxt.hw = hs[3:2];
        s_nxt.sub = hs[1:0];
        // page base from the 64 x 256 grid
        base_x = TFC_VX_W'({s_r.q.page_x, 6'h00}); // R10
        s_nxt.bx = base_x + ((s_r.q.mode == TFC_MODE_4BIT) ? TFC_VX_W'(s_r.u[7:2] & 6'h3c)
                   : (s_r.q.mode == TFC_MODE_8BIT) ? TFC_VX_W'(s_r.u[7:1] & 7'h7c) : TFC_VX_W'(s_r.u & 8'hfc));
        s_nxt.by = TFC_VY_W'({s_r.q.page_y, s_r.v});
        s_nxt.st = TFC_DONE;
        s_nxt.fcnt = 2'd0;
        s_nxt.rcnt = 2'd0;
      end
      TFC_DONE: begin
        if (!hit) begin
          s_nxt.st = TFC_FILL; // R21
          s_nxt.vr_valid = 1'b1;
          s_nxt.vr_addr = '{x: s_r.bx, y: s_r.by};
        end else if (s_r.q.mode != TFC_MODE_16BIT && (!s_r.pal_ok || s_r.pal_x != s_r.q.pal_x
                     || s_r.pal_y != s_r.q.pal_y || s_r.pal_mode != s_r.q.mode)) begin
          // different palette: reload whole row
          s_nxt.st = TFC_PAL; // R13
          s_nxt.pal_ok = 1'b0;
          s_nxt.pcnt = 9'd0;
          s_nxt.prcv = 9'd0;
          s_nxt.vr_valid = 1'b1;
          s_nxt.vr_addr = '{x: TFC_VX_W'({s_r.q.pal_x, 4'h0}), // R12
                            y: VRAM_2MB ? s_r.q.pal_y : {1'b0, s_r.q.pal_y[8:0]}}; // R12
        end else begin
          s_nxt.out_valid = 1'b1;
          s_nxt.out_texel = dec_texel;
          s_nxt.st = TFC_IDLE;
        end
      end
      TFC_FILL: begin
        // issue four halfword reads, counting the four returns alongside
        if (s_r.vr_valid) begin
          if (s_r.fcnt == 2'd3) begin
            s_nxt.vr_valid = 1'b0;
          end else begin
            s_nxt.fcnt = s_r.fcnt + 2'd1;
            s_nxt.vr_addr.x = s_r.vr_addr.x + TFC_VX_W'(1);
          end
        end
        if (vd_valid) begin
          s_nxt.rcnt = s_r.rcnt + 2'd1;
          if (s_r.rcnt == 2'd3) begin
            s_nxt.st = TFC_DONE; // R21
          end
        end
      end
      TFC_PAL: begin
        // one palette row, 16 or 256 halfwords
        if (s_r.vr_valid) begin
          if (s_r.pcnt == ((s_r.q.mode == TFC_MODE_4BIT) ? 9'(TFC_PAL_LEN_4 - 1) : 9'(TFC_PAL_LEN_8 - 1))) begin
            s_nxt.vr_valid = 1'b0; // R11
          end else begin
            s_nxt.pcnt = s_r.pcnt + 9'd1;
            s_nxt.vr_addr.x = s_r.vr_addr.x + TFC_VX_W'(1);
          end
        end
        if (vd_valid) begin
          s_nxt.prcv = s_r.prcv + 9'd1;
          if (s_r.prcv == s_r.pcnt && !s_nxt.vr_valid) begin
            s_nxt.pal_ok = 1'b1;
            s_nxt.pal_x = s_r.q.pal_x;
            s_nxt.pal_y = s_r.q.pal_y;
            s_nxt.pal_mode = s_r.q.mode;
            s_nxt.st = TFC_DONE;
          end
        end
      end
      default: s_nxt.st = TFC_IDLE;
    endcase
    s_nxt.req_ready = (s_nxt.st == TFC_IDLE); // ready straight from a flop
  end
  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // cache and palette storage writes
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < LINES; i++) begin
        valid_mem[i] <= 1'b0;
      end
    end else if (fill_we) begin
      data_mem[s_r.entry][s_r.rcnt] <= vd_data; // R21
      if (s_r.rcnt == 2'd3) begin
        tag_mem[s_r.entry] <= tag_now; // R19
        valid_mem[s_r.entry] <= 1'b1;
      end
    end
    if (pal_we) begin
      pal_mem[s_r.prcv[7:0]] <= vd_data; // R11
    end
  end
  assign req_ready = s_r.req_ready;
  assign out_valid = s_r.out_valid;
  assign out_texel = s_r.out_texel;
  assign vr_valid = s_r.vr_valid;
  assign vr_addr = s_r.vr_addr;
  assign raw_out_valid = s_r.raw_out_valid;
  assign raw_out = s_r.raw_out;
  assign fb_write_ok = s_r.fb_write_ok;
  // a miss leads to a fetch request next cycle
  property p_miss_fetch;
    @(posedge clock) disable iff (rst)
      (s_r.st == TFC_DONE && !hit) |=> (vr_valid && s_r.st == TFC_FILL);
  endproperty
  a_miss_fetch: assert property (p_miss_fetch) else $error("miss did not start fetch"); // R21
  // answer never comes without a hit
  property p_out_hit;
    @(posedge clock) disable iff (rst)
      out_valid |-> $past(hit);
  endproperty
  a_out_hit: assert property (p_out_hit) else $error("texel answered without hit"); // R19
  // zero colour is never drawn
  property p_zero_clear;
    @(posedge clock) disable iff (rst)
      (out_valid && out_texel.r == 5'h00 && out_texel.g == 5'h00 && out_texel.b == 5'h00
       && !$past(color[TFC_FLAG_BIT])) |-> !out_texel.draw;
  endproperty
  a_zero_clear: assert property (p_zero_clear) else $error("transparent texel drawn"); // R5
  // blend needs a semi command
  property p_blend_semi;
    @(posedge clock) disable iff (rst)
      (out_valid && out_texel.blend) |-> s_r.q.semi_cmd;
  endproperty
  a_blend_semi: assert property (p_blend_semi) else $error("blend under opaque command"); // R6
  // protected pixel refused
  property p_mask;
    @(posedge clock) disable iff (rst)
      (fb_check_mask && fb_old[TFC_FLAG_BIT]) |=> !fb_write_ok;
  endproperty
  a_mask: assert property (p_mask) else $error("protected pixel writable"); // R1
  // raw output follows raw input by one cycle
  property p_raw;
    @(posedge clock) disable iff (rst)
      raw_valid |=> (raw_out_valid && raw_out == $past(raw_rgb));
  endproperty
  a_raw: assert property (p_raw) else $error("raw pixel data not passed"); // R3
  // first fill read address on entry granule
  property p_fill_align;
    @(posedge clock) disable iff (rst)
      $rose(s_r.st == TFC_FILL) |-> (vr_addr.x[1:0] == 2'b00);
  endproperty
  a_fill_align: assert property (p_fill_align) else $error("entry fetch misaligned"); // R17
  // palette x aligned to 16
  property p_pal_align;
    @(posedge clock) disable iff (rst)
      $rose(s_r.st == TFC_PAL) |-> (vr_addr.x[3:0] == 4'h0);
  endproperty
  a_pal_align: assert property (p_pal_align) else $error("palette row misaligned"); // R12
endmodule

// *** src/tfc_decode.sv ***
// texel decode: palette index extraction, colour split, transparency
// pure combinational, same clock domain as the cache
`timescale 1ns/1ps
module tfc_decode
  import tfc_pkg::*;
(
  input wire logic [15:0] word,
  input wire tfc_pkg::tfc_mode_t mode,
  input wire logic [1:0] sub,
  output logic [7:0] index,
  input wire logic [15:0] color,
  input wire logic semi_cmd,
  output tfc_pkg::tfc_texel_t texel
);
  // index select from one halfword
  always_comb begin
    index = 8'h00;
    case (mode)
      TFC_MODE_8BIT: index = sub[0] ? word[15:8] : word[7:0]; // R7
      TFC_MODE_4BIT: index = {4'h0, word[sub*4 +: 4]}; // R8
      default: index = 8'h00;
    endcase
  end
  // colour split and transparency
  always_comb begin
    texel.r = color[TFC_R_LSB +: 5]; // R4
    texel.g = color[TFC_G_LSB +: 5]; // R4
    texel.b = color[TFC_B_LSB +: 5]; // R4
    texel.draw = (color != TFC_CLEAR_TEXEL); // R5
    texel.blend = texel.draw && color[TFC_FLAG_BIT] && semi_cmd; // R6
  end
endmodule

// *** src/tfc_pixel_pack.sv ***
// frame-buffer pixel helpers: mask bit write gate and 24-bit packing
// used by the cache top for its draw and raw-transfer outputs
`timescale 1ns/1ps
module tfc_pixel_pack
  import tfc_pkg::*;
(
  input wire logic [15:0] old_pixel,
  input wire logic check_mask,
  output logic write_ok,
  input wire logic [47:0] two_rgb24,
  output logic [47:0] packed_bytes
);
  // protected pixels refuse overwrite
  always_comb write_ok = !(check_mask && old_pixel[TFC_FLAG_BIT]); // R1
  // two pixels in six bytes, red lowest
  always_comb packed_bytes = two_rgb24; // R2
endmodule

// *** src/tfc_pkg.sv ***
// package for the texture fetch cache: geometry, modes, field positions, structs
// assumes a 16-bit halfword video memory port and one graphics clock
package tfc_pkg;
  // texel colour modes
  typedef enum logic [1:0] {
    TFC_MODE_4BIT = 2'b00,
    TFC_MODE_8BIT = 2'b01,
    TFC_MODE_16BIT = 2'b10
  } tfc_mode_t;

  // geometry
  localparam int TFC_COORD_W = 8;        // texel coordinate bits per axis
  localparam int TFC_ENTRIES = 256;      // entries per cache block
  localparam int TFC_ENTRY_HW = 4;       // halfwords per 8-byte entry
  localparam int TFC_CACHE_BYTES = 2048; // total cache size
  localparam int TFC_VX_W = 10;          // video memory x in halfwords
  localparam int TFC_VY_W = 10;          // video memory line
  localparam int TFC_PAGE_X_STEP = 64;   // page base x granule
  localparam int TFC_PAGE_Y_STEP = 256;  // page base y granule
  localparam int TFC_PAL_X_STEP = 16;    // palette x granule
  localparam int TFC_PAL_Y_MAX_1M = 511;  // palette row limit, 1 MB
  localparam int TFC_PAL_Y_MAX_2M = 1023; // palette row limit, 2 MB
  localparam int TFC_PAL_LEN_4 = 16;     // palette length, 4-bit mode
  localparam int TFC_PAL_LEN_8 = 256;    // palette length, 8-bit mode

  // texel and pixel field positions
  localparam int TFC_R_LSB = 0;
  localparam int TFC_G_LSB = 5;
  localparam int TFC_B_LSB = 10;
  localparam int TFC_FLAG_BIT = 15;      // semi-transparency / protect flag
  localparam logic [15:0] TFC_CLEAR_TEXEL = 16'h0000;

  // rasteriser request
  typedef struct packed {
    logic [7:0] u;
    logic [7:0] v;
    tfc_mode_t mode;
    logic [3:0] page_x;  // page base in 64-halfword steps
    logic page_y;        // page base in 256-line steps
    logic [5:0] pal_x;   // palette x in 16-halfword steps
    logic [9:0] pal_y;   // palette row
    logic [4:0] win_mask_x; // texture window mask, 8-texel units
    logic [4:0] win_mask_y;
    logic [4:0] win_off_x;
    logic [4:0] win_off_y;
    logic semi_cmd;      // command is semi-transparent
    logic rect;          // rectangle primitive
  } tfc_req_t;

  // answer to the rasteriser
  typedef struct packed {
    logic [4:0] r;
    logic [4:0] g;
    logic [4:0] b;
    logic draw;   // pixel is drawn
    logic blend;  // pixel is blended
  } tfc_texel_t;

  // video memory read request
  typedef struct packed {
    logic [TFC_VX_W-1:0] x;
    logic [TFC_VY_W-1:0] y;
  } tfc_vaddr_t;

  // 24-bit pixel byte packing and 15-bit mask bit
  localparam int TFC_RGB24_BYTES = 3;
endpackage

// *** verification/test_tfc_cache.sv ***
// testbench for the texture fetch cache
// assumes the video memory model beside it
`timescale 1ns/1ps
module test_tfc_cache;
  import tfc_pkg::*;
  logic clock, rst, req_valid, req_ready, out_valid, pal_clear, slow;
  logic vr_valid, vd_valid, raw_valid, fb_check_mask, raw_out_valid, fb_write_ok;
  tfc_req_t req; // request fields
  tfc_texel_t out_texel; // answer
  tfc_vaddr_t vr_addr, first_rd; // read address, first of a fetch
  logic [15:0] vd_data, fb_old;
  logic [47:0] raw_rgb, raw_out;
  int mismatches, check_count, rd_mark; // counters, read count at fetch start
  int rd_count = 0; // reads seen on the memory port
  tfc_cache dut_u (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .out_valid(out_valid), .out_texel(out_texel),
    .pal_clear(pal_clear), .vr_valid(vr_valid), .vr_addr(vr_addr),
    .vd_valid(vd_valid), .vd_data(vd_data), .raw_valid(raw_valid), .raw_rgb(raw_rgb),
    .fb_old(fb_old), .fb_check_mask(fb_check_mask), .raw_out_valid(raw_out_valid),
    .raw_out(raw_out), .fb_write_ok(fb_write_ok));
  tfc_vram_model vm_u (.clock(clock), .rst(rst), .slow(slow), .vr_valid(vr_valid),
    .vr_addr(vr_addr), .vd_valid(vd_valid), .vd_data(vd_data));
  // count memory reads
  always @(posedge clock) begin
    if (vr_valid === 1'b1) begin
      if (rd_count == rd_mark) begin
        first_rd <= vr_addr;
      end
      rd_count <= rd_count + 1;
    end
  end
  // compare and count
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // expected texel from a colour word
  function automatic tfc_texel_t mk(input logic [15:0] c, input logic semi);
    tfc_texel_t t;
    t.r = c[4:0];
    t.g = c[9:5];
    t.b = c[14:10];
    t.draw = c != 16'h0000;
    t.blend = c[15] & semi;
    return t;
  endfunction
  // expected texel for a request
  function automatic tfc_texel_t exp_of(input tfc_req_t q);
    int u, v, x;
    logic [15:0] w;
    logic [7:0] idx;
    u = ((q.u & ~(q.win_mask_x << 3)) | ((q.win_off_x & q.win_mask_x) << 3)) & 255;
    v = ((q.v & ~(q.win_mask_y << 3)) | ((q.win_off_y & q.win_mask_y) << 3)) & 255;
    x = q.page_x * 64 + (q.mode == TFC_MODE_16BIT ? u : q.mode == TFC_MODE_8BIT ? u / 2 : u / 4);
    w = vm_u.peek(x, q.page_y * 256 + v);
    if (q.mode == TFC_MODE_16BIT) begin
      return mk(w, q.semi_cmd);
    end
    idx = q.mode == TFC_MODE_8BIT ? w[u[0] * 8 +: 8] : {4'h0, w[u[1:0] * 4 +: 4]};
    return mk(vm_u.peek(q.pal_x * 16 + idx, q.pal_y), q.semi_cmd);
  endfunction
  // plain request
  function automatic tfc_req_t rq(input tfc_mode_t m, input logic [7:0] u, input logic [7:0] v);
    tfc_req_t q;
    q = '0;
    q.mode = m;
    q.u = u;
    q.v = v;
    return q;
  endfunction
  // one texel fetch; reads or lat below zero are not checked
  task automatic fetch(input tfc_req_t q, input int reads, input int lat);
    int n;
    rd_mark = rd_count;
    req = q;
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    #1;
    req_valid = 1'b0;
    n = 1;
    while (out_valid !== 1'b1 && n < 3000) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(out_valid, 1'b1, "answer");
    chk(out_texel, exp_of(q), "texel");
    if (reads >= 0) chk(rd_count - rd_mark, reads, "reads");
    if (lat > 0) chk(n, lat, "hit latency");
    chk(raw_out_valid, 1'b0, "raw during draw");
  endtask
  // direct texels, transparency, page base
  task automatic t_direct();
    tfc_req_t q;
    vm_u.mem[2 * 1024 + 69] = 16'h8000;
    fetch(rq(TFC_MODE_16BIT, 8'h00, 8'h00), 4, -1);
    chk(first_rd, 20'h0, "entry base");
    fetch(rq(TFC_MODE_16BIT, 8'h03, 8'h00), 0, 3);
    q = rq(TFC_MODE_16BIT, 8'h05, 8'h02);
    q.page_x = 4'h1;
    fetch(q, 4, -1);
    chk(first_rd, {10'd68, 10'd2}, "page base");
    q.semi_cmd = 1'b1;
    fetch(q, 0, 3);
    q = rq(TFC_MODE_16BIT, 8'h01, 8'h01);
    q.page_y = 1'b1;
    fetch(q, 4, -1);
    chk(first_rd, {10'd0, 10'd257}, "page line");
    $display("test direct done");
  endtask
  // block geometry and eviction per mode
  task automatic t_evict();
    tfc_mode_t m[3] = '{TFC_MODE_4BIT, TFC_MODE_8BIT, TFC_MODE_16BIT};
    int bw[3] = '{64, 32, 32};
    int per[3] = '{16, 8, 4};
    for (int i = 0; i < 3; i++) begin
      fetch(rq(m[i], 8'h00, 8'h01), -1, -1);
      fetch(rq(m[i], 8'(per[i] - 1), 8'h01), 0, 3);
      fetch(rq(m[i], 8'(per[i]), 8'h01), 4, -1);
      fetch(rq(m[i], 8'(bw[i]), 8'h01), 4, -1);
      fetch(rq(m[i], 8'h00, 8'h01), 4, -1);
    end
    $display("test evict done");
  endtask
  // palette placement, reuse and clear
  task automatic t_pal();
    tfc_req_t q;
    q = rq(TFC_MODE_8BIT, 8'h00, 8'h07);
    q.pal_x = 6'h02;
    q.pal_y = 10'd300;
    q.semi_cmd = 1'b1;
    slow = 1'b1;
    fetch(q, 256 + 4, -1);
    slow = 1'b0;
    q.u = 8'h01;
    fetch(q, 0, 3);
    pal_clear = 1'b1;
    @(posedge clock);
    #1;
    pal_clear = 1'b0;
    fetch(q, 256, -1);
    q = rq(TFC_MODE_4BIT, 8'h00, 8'h0b);
    q.pal_x = 6'h03;
    q.pal_y = 10'd5;
    fetch(q, 16 + 4, -1);
    for (int s = 1; s < 4; s++) begin
      q.u = 8'(s);
      fetch(q, 0, 3);
    end
    $display("test palette done");
  endtask
  // texture window repeat
  task automatic t_window();
    tfc_req_t q;
    q = rq(TFC_MODE_16BIT, 8'h05, 8'h4a);
    q.win_mask_x = 5'h04;
    q.win_off_x = 5'h05;
    q.win_mask_y = 5'h08;
    q.win_off_y = 5'h00;
    fetch(q, 4, -1);
    chk(first_rd, {10'h024, 10'h00a}, "window");
    $display("test window done");
  endtask
  // raw 24-bit path and protect flag
  task automatic t_raw();
    raw_valid = 1'b1;
    raw_rgb = 48'h112233_445566;
    @(posedge clock);
    #1;
    raw_valid = 1'b0;
    chk(raw_out_valid, 1'b1, "raw valid");
    chk(raw_out, 48'h112233_445566, "raw bytes");
    for (int i = 0; i < 4; i++) begin
      fb_check_mask = i[0];
      fb_old = {i[1], 15'h1234};
      @(posedge clock);
      #1;
      chk(fb_write_ok, !(i[0] && i[1]), "protect");
    end
    $display("test raw done");
  endtask
  // verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // main sequence
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    pal_clear = 1'b0;
    raw_valid = 1'b0;
    raw_rgb = '0;
    fb_old = '0;
    fb_check_mask = 1'b0;
    slow = 1'b0;
    mismatches = 0;
    check_count = 0;
    rd_mark = 0;
    repeat (3) @(posedge clock);
    #1;
    rst = 1'b0;
    t_direct();
    t_evict();
    t_pal();
    t_window();
    t_raw();
    print_verdict();
  end
  // watchdog
  initial begin
    #100000;
    mismatches++;
    $display("ERROR at %0t: watchdog", $time);
    print_verdict();
  end
endmodule

// *** verification/tfc_vram_model.sv ***
// video memory model: answers halfword reads in order
// assumes one clock; slow adds latency
`timescale 1ns/1ps
module tfc_vram_model
  import tfc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic slow,
  input wire logic vr_valid,
  input wire tfc_pkg::tfc_vaddr_t vr_addr,
  output logic vd_valid,
  output logic [15:0] vd_data
);
  logic [15:0] mem [int]; // patched words
  tfc_vaddr_t q_a[$]; // pending addresses
  int q_t[$]; // due cycle per read
  int cyc = 0; // cycle count
  // stored word: patch or default pattern
  function automatic logic [15:0] peek(input int x, input int y);
    if (mem.exists(y * 1024 + x)) begin
      return mem[y * 1024 + x];
    end
    return {y[5:0], x[9:0]};
  endfunction
  // queue reads, answer one per cycle; idle values under reset
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (rst) begin
      q_a.delete();
      q_t.delete();
      vd_valid <= 1'b0;
      vd_data <= 16'h5a5a;
    end else begin
      if (vr_valid) begin
        q_a.push_back(vr_addr);
        q_t.push_back(cyc + (slow ? 7 : 1));
      end
      if (q_t.size() > 0 && q_t[0] <= cyc) begin
        vd_valid <= 1'b1;
        vd_data <= peek(q_a[0].x, q_a[0].y);
        void'(q_a.pop_front());
        void'(q_t.pop_front());
      end else begin
        // released bus toggles
        vd_valid <= 1'b0;
        vd_data <= ~vd_data;
      end
    end
  end
endmodule
